// ===== logic/dm_port_pkg.sv
// Purpose: Constants and types for the differential Manchester communications port.
// Assumes: 10 MHz system clock; plain register port with 32-bit data.
// Notes: Register map and field positions below are local choices.
package dm_port_pkg;

  localparam int CLK_HZ = 10_000_000;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CMD_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;

  // Control and command field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam int CTRL_PRE_LSB = 5;
  localparam int CTRL_COLL_BIT = 13;
  localparam int CMD_START_BIT = 0;

  // Status field positions
  localparam int ST_TXBUSY_BIT = 0;
  localparam int ST_RXACT_BIT = 1;
  localparam int ST_COLL_BIT = 2;
  localparam int ST_UNDER_BIT = 3;
  localparam int ST_RXERR_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;

  // Reset values and least preamble length
  localparam logic MODE_RESET = 1'b0;
  localparam logic [3:0] RATE_RESET = 4'h5;
  localparam logic [7:0] PRE_RESET = 8'h10;
  localparam logic [7:0] PRE_MIN = 8'h04;

  // Bit rates in bits per second, by select code
  localparam int RATE_2M5_BPS = 2_500_000;
  localparam int RATE_1M25_BPS = 1_250_000;
  localparam int RATE_625K_BPS = 625_000;
  localparam int RATE_312K5_BPS = 312_500;
  localparam int RATE_156K_BPS = 156_000;
  localparam int RATE_78K_BPS = 78_000;
  localparam int RATE_39K_BPS = 39_000;
  localparam int RATE_19K5_BPS = 19_500;
  localparam int RATE_9K6_BPS = 9_600;
  localparam int RATE_4K8_BPS = 4_800;
  localparam int RATE_MAX_SEL = 9;

  // Least system clock for the two fastest rates
  localparam int MIN_CLK_2M5_HZ = 40_000_000;
  localparam int MIN_CLK_1M25_HZ = 20_000_000;

  // End-of-packet hold in half bits, and receiver violation point in eighths of a bit
  localparam int VIOL_HALVES = 5;
  localparam int RX_VIOL_EIGHTHS = 11;
  localparam int RX_DATA_WIN_QUARTERS = 3;

  typedef enum logic [2:0] {TX_IDLE, TX_LOW, TX_WAIT, TX_BITS, TX_VIOL} tx_state_t;
  typedef enum logic [1:0] {FLD_SYNC, FLD_BYTESYNC, FLD_DATA} tx_field_t;
  typedef enum logic [1:0] {RX_HUNT, RX_SYNC, RX_DATA} rx_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } tx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic frame_end;
  } rx_byte_t;

  function automatic int rate_bps(input logic [3:0] sel);
    case (sel)
      4'h0: rate_bps = RATE_2M5_BPS;
      4'h1: rate_bps = RATE_1M25_BPS;
      4'h2: rate_bps = RATE_625K_BPS;
      4'h3: rate_bps = RATE_312K5_BPS;
      4'h4: rate_bps = RATE_156K_BPS;
      4'h5: rate_bps = RATE_78K_BPS;
      4'h6: rate_bps = RATE_39K_BPS;
      4'h7: rate_bps = RATE_19K5_BPS;
      4'h8: rate_bps = RATE_9K6_BPS;
      default: rate_bps = RATE_4K8_BPS;
    endcase
  endfunction : rate_bps

  // Half bit period in system clocks
  function automatic logic [12:0] half_cycles(input logic [3:0] sel);
    half_cycles = 13'(CLK_HZ / (2 * rate_bps(sel)));
  endfunction : half_cycles

  // Fast rates are refused when the system clock is too slow
  function automatic logic rate_ok(input logic [3:0] sel);
    if (sel > 4'(RATE_MAX_SEL)) begin
      rate_ok = 1'b0;
    end else if (sel == 4'h0) begin
      rate_ok = (CLK_HZ >= MIN_CLK_2M5_HZ);
    end else if (sel == 4'h1) begin
      rate_ok = (CLK_HZ >= MIN_CLK_1M25_HZ);
    end else begin
      rate_ok = 1'b1;
    end
  endfunction : rate_ok

endpackage : dm_port_pkg

// ===== logic/dm_comm_port.sv
// Purpose: Differential Manchester single-ended communications port, transmit and receive.
// Assumes: 10 MHz clock; rates above 625 kbps are refused at this clock.
// Notes: Special-purpose mode framing is not built; in that mode the port stays idle.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module dm_comm_port
  import dm_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Transmit byte stream
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // Receive byte stream
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  // Line pins
  input wire logic line_rx_data_in_i,
  input wire logic line_collision_in_n_i,
  output logic line_tx_data_out_o,
  output logic line_tx_enable_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole block state, registered in one place
  typedef struct packed {
    logic mode;
    logic [3:0] rate;
    logic [7:0] pre_len;
    logic coll_en;
    logic st_coll;
    logic st_under;
    logic st_rxerr;
    logic st_refused;
    tx_state_t tx;
    tx_field_t fld;
    logic [12:0] tcnt;
    logic tphase;
    logic [7:0] pre_left;
    logic [7:0] tsh;
    logic [2:0] tbits;
    logic tlast_cur;
    logic [7:0] thold;
    logic thold_full;
    logic thold_last;
    logic got_last;
    logic cur_bit;
    logic line;
    logic txen;
    logic ready;
    logic [2:0] csync;
    logic [2:0] rsync;
    logic rlvl;
    rx_state_t rx;
    logic [12:0] rcnt;
    logic rzero;
    logic [7:0] rsh;
    logic [2:0] rbits;
    logic [7:0] rdata;
    logic rvalid;
    logic rend;
    logic [31:0] rd_data;
  } state_t;

  state_t r_reg;
  state_t r_next;
  reg_req_t req;
  tx_byte_t txb;

  // Bus and byte inputs bundled into the package carriers
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign txb = '{data: tx_data_i, valid: tx_valid_i, last: tx_last_i};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [12:0] half;
    logic [12:0] rx_win;
    logic [12:0] rx_viol;
    logic [7:0] pre;
    logic nbit;
    logic have_bit;
    logic rbit;
    r_next = r_reg;
    half = half_cycles(r_reg.rate);
    rx_win = 13'((32'(half) * 2 * RX_DATA_WIN_QUARTERS) / 4);
    rx_viol = 13'((32'(half) * 2 * RX_VIOL_EIGHTHS) / 8);
    pre = 8'h00;
    nbit = 1'b0;
    have_bit = 1'b0;
    rbit = 1'b0;
    r_next.rvalid = 1'b0;
    r_next.rend = 1'b0;
    r_next.rd_data = 32'h0000_0000;

    // Register writes; clears come first so a same-cycle event still sets
    if (req.wr) begin
      if (req.addr == CTRL_OFS) begin
        r_next.mode = req.wdata[CTRL_MODE_BIT];
        r_next.coll_en = req.wdata[CTRL_COLL_BIT];
        pre = req.wdata[CTRL_PRE_LSB +: 8];
        r_next.pre_len = (pre < PRE_MIN) ? PRE_MIN : pre;
        if (rate_ok(req.wdata[CTRL_RATE_LSB +: 4])) begin
          r_next.rate = req.wdata[CTRL_RATE_LSB +: 4];
        end else begin
          // Too fast for this clock or code above 9: old rate kept, flag raised
          r_next.st_refused = 1'b1;
        end
      end else if (req.addr == STATUS_OFS) begin
        r_next.st_coll = r_reg.st_coll & ~req.wdata[ST_COLL_BIT];
        r_next.st_under = r_reg.st_under & ~req.wdata[ST_UNDER_BIT];
        r_next.st_rxerr = r_reg.st_rxerr & ~req.wdata[ST_RXERR_BIT];
        r_next.st_refused = r_reg.st_refused & ~req.wdata[ST_REFUSED_BIT];
      end
    end

    // Register reads, data valid in the following cycle only
    if (req.rd) begin
      if (req.addr == CTRL_OFS) begin
        r_next.rd_data[CTRL_MODE_BIT] = r_reg.mode;
        r_next.rd_data[CTRL_RATE_LSB +: 4] = r_reg.rate;
        r_next.rd_data[CTRL_PRE_LSB +: 8] = r_reg.pre_len;
        r_next.rd_data[CTRL_COLL_BIT] = r_reg.coll_en;
      end else if (req.addr == STATUS_OFS) begin
        r_next.rd_data[ST_TXBUSY_BIT] = (r_reg.tx != TX_IDLE);
        r_next.rd_data[ST_RXACT_BIT] = (r_reg.rx != RX_HUNT);
        r_next.rd_data[ST_COLL_BIT] = r_reg.st_coll;
        r_next.rd_data[ST_UNDER_BIT] = r_reg.st_under;
        r_next.rd_data[ST_RXERR_BIT] = r_reg.st_rxerr;
        r_next.rd_data[ST_REFUSED_BIT] = r_reg.st_refused;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Byte intake: one holding byte keeps the shifter fed without gaps
    if (r_reg.ready && txb.valid) begin
      r_next.thold = txb.data;
      r_next.thold_full = 1'b1;
      r_next.thold_last = txb.last;
      r_next.got_last = txb.last;
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter
    case (r_reg.tx)
      TX_IDLE: begin
        r_next.txen = 1'b0;
        // Start is ignored in special-purpose mode; the port then stays idle
        if (req.wr && req.addr == CMD_OFS && req.wdata[CMD_START_BIT] && !r_reg.mode) begin
          r_next.tx = TX_LOW;
          r_next.got_last = 1'b0;
          r_next.thold_full = 1'b0;
        end
      end
      TX_LOW: begin
        // Line low first so that the first packet edge rises
        r_next.line = 1'b0;
        r_next.tx = TX_WAIT;
      end
      TX_WAIT: begin
        r_next.txen = 1'b1;
        // First clock edge comes half a bit after enable, well inside one bit
        r_next.tcnt = half - 13'd1;
        r_next.tx = TX_BITS;
        r_next.tphase = 1'b1;
        r_next.fld = FLD_SYNC;
        r_next.pre_left = r_reg.pre_len;
      end
      TX_BITS: begin
        if (r_reg.tcnt != 13'd0) begin
          r_next.tcnt = r_reg.tcnt - 13'd1;
        end else if (!r_reg.tphase) begin
          r_next.tphase = 1'b1;
          r_next.tcnt = half - 13'd1;
          if (!r_reg.cur_bit) begin
            r_next.line = ~r_reg.line;
          end
        end else begin
          // Pick the next bit; the first one leaves half a bit after enable
          case (r_reg.fld)
            FLD_SYNC: begin
              if (r_reg.pre_left != 8'h00) begin
                nbit = 1'b1;
                have_bit = 1'b1;
                r_next.pre_left = r_reg.pre_left - 8'h01;
              end else begin
                nbit = 1'b0;
                have_bit = 1'b1;
                r_next.fld = FLD_BYTESYNC;
              end
            end
            default: begin
              if (r_reg.fld == FLD_DATA && r_reg.tbits != 3'd0) begin
                nbit = r_reg.tsh[7];
                have_bit = 1'b1;
                r_next.tsh = {r_reg.tsh[6:0], 1'b0};
                r_next.tbits = r_reg.tbits - 3'd1;
              end else if (r_reg.fld == FLD_DATA && r_reg.tlast_cur) begin
                have_bit = 1'b0;
              end else if (r_reg.thold_full) begin
                nbit = r_reg.thold[7];
                have_bit = 1'b1;
                r_next.fld = FLD_DATA;
                r_next.tsh = {r_reg.thold[6:0], 1'b0};
                r_next.tbits = 3'd7;
                r_next.tlast_cur = r_reg.thold_last;
                r_next.thold_full = 1'b0;
              end else begin
                // Holding byte empty when needed: flag it and end the packet
                r_next.st_under = 1'b1;
              end
            end
          endcase
          if (have_bit) begin
            r_next.line = ~r_reg.line;
            r_next.cur_bit = nbit;
            r_next.tphase = 1'b0;
            r_next.tcnt = half - 13'd1;
          end else begin
            // No trailing clock edge; line holds its level for the hold time
            r_next.tx = TX_VIOL;
            r_next.tcnt = 13'(32'(half) * VIOL_HALVES - 1);
          end
        end
      end
      TX_VIOL: begin
        if (r_reg.tcnt != 13'd0) begin
          // Line is left alone here, so the hold keeps the last level
          r_next.tcnt = r_reg.tcnt - 13'd1;
        end else begin
          r_next.txen = 1'b0;
          r_next.tx = TX_IDLE;
          r_next.thold_full = 1'b0;
        end
      end
      default: r_next.tx = TX_IDLE;
    endcase

    // Ready only once enable is up, so no byte is asked for outside a packet
    r_next.ready = (r_next.tx == TX_BITS) &&
                   !r_next.thold_full && !r_next.got_last;

    //////////////////////////////////////////////////////////////////////////
    // Collision input: three stages, acted on when the last two are both low
    r_next.csync = {r_reg.csync[1:0], line_collision_in_n_i};
    if (r_reg.coll_en && r_reg.txen && !r_reg.csync[2] && !r_reg.csync[1]) begin
      // Sticky until cleared; a same-cycle clear loses to the event
      r_next.st_coll = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Receiver: only edges count, never levels, so polarity is irrelevant
    r_next.rsync = {r_reg.rsync[1:0], line_rx_data_in_i};
    if (r_reg.rsync[2] == r_reg.rsync[1] && r_reg.rsync[2] != r_reg.rlvl) begin
      r_next.rlvl = r_reg.rsync[2];
      if (r_reg.rx == RX_HUNT) begin
        if (!r_reg.mode) begin
          r_next.rx = RX_SYNC;
          r_next.rcnt = 13'd0;
          r_next.rzero = 1'b0;
        end
      end else if (r_reg.rcnt < rx_win) begin
        r_next.rzero = 1'b1;
        r_next.rcnt = r_reg.rcnt + 13'd1;
      end else begin
        // Clock edge closes the previous bit and restarts both windows
        rbit = ~r_reg.rzero;
        r_next.rcnt = 13'd0;
        r_next.rzero = 1'b0;
        if (r_reg.rx == RX_SYNC) begin
          if (!rbit) begin
            r_next.rx = RX_DATA;
            r_next.rbits = 3'd0;
          end
        end else begin
          r_next.rsh = {r_reg.rsh[6:0], rbit};
          r_next.rbits = r_reg.rbits + 3'd1;
          if (r_reg.rbits == 3'd7) begin
            r_next.rdata = {r_reg.rsh[6:0], rbit};
            r_next.rvalid = 1'b1;
          end
        end
      end
    end else if (r_reg.rx != RX_HUNT) begin
      if (r_reg.rcnt >= rx_viol) begin
        // A stray edge ahead of the preamble also times out here; hunting restarts
        // Missing clock edge: last bit has no trailing edge, settle it here
        r_next.rx = RX_HUNT;
        r_next.rend = 1'b1;
        rbit = ~r_reg.rzero;
        if (r_reg.rx == RX_DATA) begin
          if (r_reg.rbits == 3'd7) begin
            r_next.rdata = {r_reg.rsh[6:0], rbit};
            r_next.rvalid = 1'b1;
          end else begin
            r_next.st_rxerr = 1'b1;
          end
        end else begin
          r_next.st_rxerr = 1'b1;
        end
      end else begin
        r_next.rcnt = r_reg.rcnt + 13'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.mode <= MODE_RESET;
      r_reg.rate <= RATE_RESET;
      r_reg.pre_len <= PRE_RESET;
      // Collision input idles high; starting there avoids a false flag
      r_reg.csync <= 3'h7;
      r_reg.tx <= TX_IDLE;
      r_reg.rx <= RX_HUNT;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register; both line outputs always driven
  assign reg_rdata_o = r_reg.rd_data;
  assign tx_ready_o = r_reg.ready;
  assign rx_data_o = r_reg.rdata;
  assign rx_valid_o = r_reg.rvalid;
  assign rx_end_o = r_reg.rend;
  assign line_tx_data_out_o = r_reg.line;
  assign line_tx_enable_out_o = r_reg.txen;

endmodule : dm_comm_port

// ===== testbench/dm_line_xcvr.sv
// Purpose: Loopback line transceiver model for the port bench.
// Assumes: Medium idles at its last driven level.
// Notes: Polarity flip and collision are commanded by the bench.
`timescale 1ns/1ps
module dm_line_xcvr (
  // Clock
  input wire logic clk_i,
  // Port side
  input wire logic txd_i,
  input wire logic txen_i,
  output logic rxd_o,
  output logic coll_n_o,
  // Bench commands
  input wire logic flip_i,
  input wire logic coll_req_i
);
  logic lvl_reg = 1'b0;
  ////////////////////////////////////////////////////////////
  // Only a driving port moves the medium; idle keeps its level
  always @(posedge clk_i) begin
    if (txen_i) begin
      lvl_reg <= txd_i ^ flip_i;
    end
  end
  assign rxd_o = lvl_reg;
  assign coll_n_o = !(coll_req_i && txen_i);
endmodule : dm_line_xcvr

// ===== testbench/dm_comm_port_asserts.sv
// Purpose: Line timing checks for dm_comm_port.
// Assumes: Packets go out at rate code 2, half bit of 8 clocks.
// Notes: Helper counts clocks since the data output last moved.
`timescale 1ns/1ps
module dm_comm_port_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire logic rx_end_o,
  input wire logic line_tx_data_out_o,
  input wire logic line_tx_enable_out_o
);
  localparam int HALF = 8;
  typedef struct packed {logic txd_d; logic in_pkt; logic [7:0] gap;} mon_t;
  mon_t mon_reg;
  mon_t mon_next;
  logic moved;
  assign moved = line_tx_data_out_o != mon_reg.txd_d;
  always_comb begin
    mon_next = mon_reg;
    mon_next.txd_d = line_tx_data_out_o;
    mon_next.in_pkt = line_tx_enable_out_o && (mon_reg.in_pkt || moved);
    if (moved) begin
      mon_next.gap = 8'h01;
    end else if (mon_reg.gap != 8'hff) begin
      mon_next.gap = mon_reg.gap + 8'h01;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_low_first: assert property ($rose(line_tx_enable_out_o) |->
    !line_tx_data_out_o && !$past(line_tx_data_out_o)) else $error("data not low at enable");
  chk_first_rise: assert property ($rose(line_tx_enable_out_o) |->
    ##[1:16] $rose(line_tx_data_out_o)) else $error("no rising edge within one bit");
  chk_edge_grid: assert property (line_tx_enable_out_o && mon_reg.in_pkt && moved |->
    mon_reg.gap == 8'(HALF) || mon_reg.gap == 8'(2 * HALF)) else $error("edge off the half bit grid");
  chk_viol_len: assert property ($fell(line_tx_enable_out_o) |->
    mon_reg.gap >= 8'(5 * HALF)) else $error("end hold too short");
  chk_en_release: assert property ($fell(line_tx_enable_out_o) |->
    mon_reg.gap <= 8'(7 * HALF + 2)) else $error("enable held too long");
  chk_en_hold: assert property ($rose(line_tx_enable_out_o) |=>
    line_tx_enable_out_o [*8]) else $error("enable dropped early");
  chk_ready_in_tx: assert property (tx_ready_o |-> line_tx_enable_out_o)
    else $error("ready outside a packet");
  chk_byte_pulse: assert property (rx_valid_o |=> !rx_valid_o) else $error("byte pulse too long");
  chk_end_pulse: assert property (rx_end_o |=> !rx_end_o) else $error("end pulse too long");
endmodule : dm_comm_port_asserts
bind dm_comm_port dm_comm_port_asserts u_dm_comm_port_asserts (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_end_o(rx_end_o),
  .line_tx_data_out_o(line_tx_data_out_o), .line_tx_enable_out_o(line_tx_enable_out_o));

// ===== testbench/diff_manchester_comm_port_tb.sv
// Purpose: Self-checking bench for dm_comm_port over a loopback line.
// Assumes: 10 MHz clock; packets at rate code 2.
// Notes: Received bytes must match the sent ones whatever the polarity.
`timescale 1ns/1ps
module diff_manchester_comm_port_tb;
  import dm_port_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic flip = 1'b0;
  logic coll_req = 1'b0;
  logic [31:0] rdata;
  logic [7:0] rx_data;
  logic tx_ready, rx_valid, rx_end, rxd, coll_n, txd, txen;
  int mismatches = 0;
  int n_tests = 0;
  int end_cnt = 0;
  integer seed = 32'h0bd2b2e3;
  logic [7:0] rx_q[$];
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  dm_comm_port u_dm_comm_port (.clk_sys_i(clk_sys), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_stb), .reg_rd_i(rd_stb), .reg_rdata_o(rdata), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_end_o(rx_end), .line_rx_data_in_i(rxd), .line_collision_in_n_i(coll_n),
    .line_tx_data_out_o(txd), .line_tx_enable_out_o(txen));
  dm_line_xcvr u_dm_line_xcvr (.clk_i(clk_sys), .txd_i(txd), .txen_i(txen), .rxd_o(rxd),
    .coll_n_o(coll_n), .flip_i(flip), .coll_req_i(coll_req));
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (rx_end === 1'b1) end_cnt++;
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] ctrl_val(input logic m, input logic [3:0] r, input logic [7:0] p, input logic c);
    ctrl_val = {18'h0, c, p, r, m};
  endfunction : ctrl_val
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask : reg_read
  // The first byte is offered before START, so it is never late
  task automatic send_pkt(input int n, input logic c);
    logic [7:0] b[$];
    int i;
    int g;
    int e0;
    for (i = 0; i < n; i++) b.push_back(8'($random(seed)));
    rx_q.delete();
    e0 = end_cnt;
    @(posedge clk_sys);
    tx_data <= b[0];
    tx_valid <= 1'b1;
    tx_last <= (n == 1);
    coll_req <= c;
    flip <= 1'($random(seed));
    reg_write(CMD_OFS, 32'h1);
    i = 0;
    g = 0;
    while (i < n && g < 2000) begin
      @(posedge clk_sys);
      g++;
      if (tx_ready === 1'b1) begin
        i++;
        tx_data <= (i < n) ? b[i % n] : 8'h00;
        tx_last <= (i == n - 1);
        tx_valid <= (i < n);
      end
    end
    while ((end_cnt == e0 || txen !== 1'b0) && g < 4000) begin
      @(posedge clk_sys);
      g++;
    end
    coll_req <= 1'b0;
    chk(32'(g >= 4000), 32'h0);
    chk(32'(rx_q.size()), 32'(n));
    for (i = 0; i < n && i < rx_q.size(); i++) chk(32'(rx_q[i]), 32'(b[i]));
    $display("packet of %0d bytes done", n);
  endtask : send_pkt
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [7:0] pre;
    int k;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    reg_read(CTRL_OFS, d);
    chk(d, ctrl_val(1'b0, 4'h5, 8'h10, 1'b0));
    reg_read(4'hc, d);
    chk(d, 32'h0);
    for (k = 0; k < 16; k++) begin
      reg_write(CTRL_OFS, ctrl_val(1'b0, 4'(k), 8'h10, 1'b0));
      reg_read(CTRL_OFS, d);
      chk(32'(d[4:1]), (k < 2) ? 32'h5 : ((k > 9) ? 32'h9 : 32'(k)));
      reg_read(STATUS_OFS, d);
      chk(32'(d[ST_REFUSED_BIT]), 32'(k < 2 || k > 9));
      reg_write(STATUS_OFS, 32'h20);
    end
    $display("rate sweep done");
    reg_write(CTRL_OFS, ctrl_val(1'b0, 4'h2, 8'h02, 1'b0));
    reg_read(CTRL_OFS, d);
    chk(32'(d[12:5]), 32'(PRE_MIN));
    for (k = 0; k < 6; k++) begin
      pre = 8'h04 + 8'($random(seed) & 3);
      reg_write(CTRL_OFS, ctrl_val(1'b0, 4'h2, pre, k[0]));
      send_pkt((k == 0) ? 1 : 1 + ($random(seed) & 3), k[1]);
      reg_read(STATUS_OFS, d);
      chk(32'(d[2:0]), 32'({k[0] & k[1], 2'b00}));
      reg_write(STATUS_OFS, 32'h1c);
    end
    reg_write(CTRL_OFS, ctrl_val(1'b1, 4'h2, 8'h04, 1'b0));
    reg_write(CMD_OFS, 32'h1);
    repeat (40) @(posedge clk_sys);
    chk(32'(txen), 32'h0);
    $display("mode test done");
    stop_test();
  end
  initial begin
    #3_000_000;
    mismatches++;
    stop_test();
  end
endmodule : diff_manchester_comm_port_tb
